// ---- rtl/tcc_top.v ----
// Contract
// R1 - Control bits 7,6,5,1,0; bits 4..2 reserved
// R2 - Host writes reserved bits as zero
// R3 - Cadence off: enabled outputs steady on
// R4 - Cadence on: outputs follow on/off times
// R5 - Off-time reads show enable bits zero
// R6 - On-period end sets flag, masked interrupt
// R7 - Host may reload timer then rewrite
// R8 - Timer runs even with no enables
// R9 - Continuous mode repeats until host changes
// R10 - One-shot: tones on one on-period
// R11 - One-shot dial pulse: relay off one period
// R12 - One-shot clears enables after off-period
// R13 - One-shot interrupts at on-period end
// R14 - Dial-pulse enable toggles output pin one
// R15 - Tone B enable drives generator B
// R16 - Tone A enable drives generator A
// R17 - Control byte resets to zero
// R18 - On/off times: 11 bits, 5 ms steps
// R19 - Zero off-time keeps functions on
//
// Purpose: Signal generator control byte and cadence sequencer
// Assumes: Plain register port, read data one cycle after strobe
// Notes:   Timer runs whenever cadencing or one-shot is selected
`timescale 1ns/100ps
`default_nettype none
`include "tcc_defs.vh"

module tcc_top #(
    parameter [19:0] STEP_CYCLES = `TCC_STEP_CYCLES
) (
    // Clock and reset
    input  wire        i_clk_sys,
    input  wire        i_rst,
    // Register port
    input  wire [7:0]  i_addr,
    input  wire [15:0] i_wdata,
    input  wire        i_wr,
    input  wire        i_rd,
    output reg  [15:0] o_rdata,
    // Generator and relay controls
    output reg         o_tone_a_on,
    output reg         o_tone_b_on,
    output reg         o_gp_output_one,
    // Interrupt
    output reg         o_irq
);

    localparam ST_IDLE = 2'd0;
    localparam ST_ON   = 2'd1;
    localparam ST_OFF  = 2'd2;

    reg  [7:0]  ctrl_reg;
    reg  [7:0]  ctrl_next;
    reg  [10:0] cad_on_reg;
    reg  [10:0] cad_off_reg;
    reg  [1:0]  irq_en_reg;
    reg  [1:0]  state_reg;
    reg  [1:0]  state_next;
    reg  [10:0] step_cnt_reg;
    reg  [10:0] step_cnt_next;
    reg  [1:0]  irq_event;
    reg         restart;
    wire        step;
    wire [1:0]  irq_status;
    wire        irq_line;

    wire cad_en   = ctrl_reg[`TCC_BIT_CAD_EN];
    wire one_shot = ctrl_reg[`TCC_BIT_ONE_SHOT];

    // Reserved bits are stored as written; host keeps them zero
    function [7:0] ctrl_mask;
        input [7:0] v;
        begin
            ctrl_mask = v; // R1
        end
    endfunction

    // Enable bits gated by the cadence phase
    function [7:0] ctrl_view;
        input [7:0] v;
        input       off_phase;
        begin
            ctrl_view = v;
            if (off_phase) begin
                ctrl_view[`TCC_BIT_DP_EN] = 1'b0; // R5
                ctrl_view[`TCC_BIT_TB_EN] = 1'b0; // R5
                ctrl_view[`TCC_BIT_TA_EN] = 1'b0; // R5
            end
        end
    endfunction

    // Address decode shared by every register write target
    function reg_hit;
        input       strobe;
        input [7:0] addr;
        input [7:0] target;
        begin
            reg_hit = strobe && (addr == target);
        end
    endfunction

    // Period end test; one bit wider so a full count cannot wrap
    function period_end;
        input [10:0] cnt;
        input [10:0] limit;
        begin
            period_end = ({1'b0, cnt} + 12'h001) >= {1'b0, limit};
        end
    endfunction

    // Next step count within a period
    function [10:0] step_inc;
        input [10:0] cnt;
        begin
            step_inc = cnt + 11'h001;
        end
    endfunction

    // Read mux; write-only and unmapped addresses read as zero
    function [15:0] read_word;
        input [7:0]  addr;
        input [7:0]  ctrl;
        input [10:0] on_time;
        input [10:0] off_time;
        input [1:0]  status;
        input [1:0]  enable;
        begin
            case (addr)
                `TCC_ADDR_CTRL:     read_word = {8'h00, ctrl}; // R5
                `TCC_ADDR_CAD_ON:   read_word = {5'h00, on_time};
                `TCC_ADDR_CAD_OFF:  read_word = {5'h00, off_time};
                `TCC_ADDR_IRQ_STAT: read_word = {14'h0000, status};
                `TCC_ADDR_IRQ_EN:   read_word = {14'h0000, enable};
                default:            read_word = 16'h0000;
            endcase
        end
    endfunction

    wire wr_ctrl = reg_hit(i_wr, i_addr, `TCC_ADDR_CTRL);
    wire wr_on   = reg_hit(i_wr, i_addr, `TCC_ADDR_CAD_ON);
    wire wr_off  = reg_hit(i_wr, i_addr, `TCC_ADDR_CAD_OFF);
    wire wr_en   = reg_hit(i_wr, i_addr, `TCC_ADDR_IRQ_EN);
    wire wr_clr  = reg_hit(i_wr, i_addr, `TCC_ADDR_IRQ_CLR);

    tcc_step_div #(
        .STEP_CYCLES (STEP_CYCLES)
    ) u_div (
        .i_clk_sys (i_clk_sys),
        .i_rst     (i_rst),
        .i_restart (restart),
        .o_step    (step)
    );

    tcc_irq u_irq (
        .i_clk_sys (i_clk_sys),
        .i_rst     (i_rst),
        .i_event   (irq_event),
        .i_clear   (wr_clr ? i_wdata[1:0] : 2'h0),
        .i_enable  (irq_en_reg),
        .o_status  (irq_status),
        .o_irq     (irq_line)
    );

    // Cadence sequencer; a control write restarts it with fresh timing
    always @* begin
        state_next    = state_reg;
        step_cnt_next = step_cnt_reg;
        ctrl_next     = ctrl_reg;
        irq_event     = 2'h0;
        restart       = 1'b0;
        case (state_reg)
            ST_IDLE: begin
                step_cnt_next = 11'h000;
            end
            ST_ON: begin
                if (step) begin
                    if (period_end(step_cnt_reg, cad_on_reg)) begin
                        irq_event[`TCC_IRQ_CAD_DONE] = 1'b1; // R6 R8
                        irq_event[`TCC_IRQ_ONESHOT] = one_shot; // R13
                        step_cnt_next = 11'h000;
                        if (cad_off_reg == 11'h000 && !one_shot)
                            state_next = ST_ON; // R19
                        else
                            state_next = ST_OFF; // R4 R10 R11
                    end else begin
                        step_cnt_next = step_inc(step_cnt_reg); // R18
                    end
                end
            end
            ST_OFF: begin
                if (step) begin
                    if (period_end(step_cnt_reg, cad_off_reg)) begin
                        step_cnt_next = 11'h000;
                        if (one_shot) begin
                            ctrl_next  = 8'h00; // R12
                            state_next = ST_IDLE;
                        end else begin
                            state_next = ST_ON; // R9
                        end
                    end else begin
                        step_cnt_next = step_inc(step_cnt_reg); // R18
                    end
                end
            end
            default: begin
                state_next = ST_IDLE;
            end
        endcase
        if (wr_ctrl) begin
            ctrl_next     = ctrl_mask(i_wdata[7:0]); // R1 R7
            restart       = 1'b1;
            step_cnt_next = 11'h000;
            if (i_wdata[`TCC_BIT_CAD_EN] || i_wdata[`TCC_BIT_ONE_SHOT])
                state_next = ST_ON;
            else
                state_next = ST_IDLE; // R3
        end
    end

    always @(posedge i_clk_sys or posedge i_rst) begin
        if (i_rst) begin
            ctrl_reg     <= `TCC_CTRL_RESET; // R17
            state_reg    <= ST_IDLE;
            step_cnt_reg <= 11'h000;
        end else begin
            ctrl_reg     <= ctrl_next;
            state_reg    <= state_next;
            step_cnt_reg <= step_cnt_next;
        end
    end

    // A new time applies to the period already running
    always @(posedge i_clk_sys or posedge i_rst) begin
        if (i_rst) begin
            cad_on_reg <= `TCC_CAD_ON_RESET;
        end else if (wr_on) begin
            cad_on_reg <= i_wdata[10:0]; // R18
        end
    end

    always @(posedge i_clk_sys or posedge i_rst) begin
        if (i_rst) begin
            cad_off_reg <= `TCC_CAD_OFF_RESET;
        end else if (wr_off) begin
            cad_off_reg <= i_wdata[10:0]; // R18
        end
    end

    // Enable 1 lets a status bit through, the inverse of a mask
    always @(posedge i_clk_sys or posedge i_rst) begin
        if (i_rst) begin
            irq_en_reg <= 2'h0;
        end else if (wr_en) begin
            irq_en_reg <= i_wdata[1:0]; // R6
        end
    end

    // Outputs: steady when idle with cadence off, gated when cadencing
    wire off_phase = (state_reg == ST_OFF);
    wire active    = cad_en || one_shot ? (state_reg == ST_ON) : 1'b1;
    wire [7:0] view = ctrl_view(ctrl_reg, off_phase);

    always @(posedge i_clk_sys or posedge i_rst) begin
        if (i_rst) begin
            o_tone_a_on <= 1'b0;
            o_tone_b_on <= 1'b0;
        end else begin
            o_tone_a_on <= ctrl_reg[`TCC_BIT_TA_EN] && active; // R16 R3 R4
            o_tone_b_on <= ctrl_reg[`TCC_BIT_TB_EN] && active; // R15 R3 R4
        end
    end

    // Relay drive high passes loop current; a break opens it
    always @(posedge i_clk_sys or posedge i_rst) begin
        if (i_rst) begin
            o_gp_output_one <= 1'b1;
        end else if (!ctrl_reg[`TCC_BIT_DP_EN]) begin
            o_gp_output_one <= 1'b1;
        end else begin
            o_gp_output_one <= !active; // R14 R11
        end
    end

    // Extra stage keeps the pin on a top-level flop; costs one cycle
    always @(posedge i_clk_sys or posedge i_rst) begin
        if (i_rst) begin
            o_irq <= 1'b0;
        end else begin
            o_irq <= irq_line; // R6
        end
    end

    // Read data stand for the one cycle after the strobe, else zero
    always @(posedge i_clk_sys or posedge i_rst) begin
        if (i_rst) begin
            o_rdata <= 16'h0000;
        end else if (i_rd) begin
            o_rdata <= read_word(i_addr, view, cad_on_reg, cad_off_reg,
                                 irq_status, irq_en_reg);
        end else begin
            o_rdata <= 16'h0000;
        end
    end

endmodule // tcc_top
`default_nettype wire

// ---- rtl/tcc_defs.vh ----
// Purpose: Constants for the tone cadence control block
// Assumes: 200 MHz system clock
// Notes:   Register indices on the plain register port
`ifndef TCC_DEFS_VH
`define TCC_DEFS_VH

// Register addresses (8-bit address port)
`define TCC_ADDR_CTRL      8'hDE
`define TCC_ADDR_CAD_ON    8'hE0
`define TCC_ADDR_CAD_OFF   8'hE2
`define TCC_ADDR_IRQ_STAT  8'hF0
`define TCC_ADDR_IRQ_CLR   8'hF1
`define TCC_ADDR_IRQ_EN    8'hF2

// Control byte fields
`define TCC_BIT_CAD_EN     7
`define TCC_BIT_ONE_SHOT   6
`define TCC_BIT_DP_EN      5
`define TCC_BIT_TB_EN      1
`define TCC_BIT_TA_EN      0
`define TCC_CTRL_RESET     8'h00

// Cadence timer reset values
`define TCC_CAD_ON_RESET   11'h190
`define TCC_CAD_OFF_RESET  11'h320

// Interrupt status fields
`define TCC_IRQ_CAD_DONE   0
`define TCC_IRQ_ONESHOT    1

// Cadence step: 5 ms at 200 MHz
`define TCC_STEP_MS        5
`define TCC_CLK_MHZ        200
`define TCC_STEP_CYCLES    (`TCC_STEP_MS * 1000 * `TCC_CLK_MHZ)

`endif

// ---- rtl/tcc_step_div.v ----
// Purpose: Divides the system clock into a cadence step enable
// Assumes: One clock domain
// Notes:   Restarts when i_restart is high
`timescale 1ns/100ps
`default_nettype none
`include "tcc_defs.vh"

module tcc_step_div #(
    parameter [19:0] STEP_CYCLES = `TCC_STEP_CYCLES
) (
    // Clock and reset
    input  wire       i_clk_sys,
    input  wire       i_rst,
    // Control
    input  wire       i_restart,
    // Step pulse
    output reg        o_step
);

    reg [19:0] cnt_reg;

    always @(posedge i_clk_sys or posedge i_rst) begin
        if (i_rst) begin
            cnt_reg <= 20'h0_0000;
            o_step  <= 1'b0;
        end else if (i_restart) begin
            // Preload one: the registered pulse costs a cycle, and this
            // keeps the first step a full period after the restart
            cnt_reg <= 20'h0_0001;
            o_step  <= 1'b0;
        end else if (cnt_reg >= STEP_CYCLES - 20'h0_0001) begin
            cnt_reg <= 20'h0_0000;
            o_step  <= 1'b1;
        end else begin
            cnt_reg <= cnt_reg + 20'h0_0001;
            o_step  <= 1'b0;
        end
    end

endmodule // tcc_step_div
`default_nettype wire

// ---- rtl/tcc_irq.v ----
// Purpose: Sticky interrupt status, enable and clear
// Assumes: Events are one-cycle pulses
// Notes:   A set in the clear cycle wins over the clear
`timescale 1ns/100ps
`default_nettype none

module tcc_irq (
    // Clock and reset
    input  wire       i_clk_sys,
    input  wire       i_rst,
    // Events and software access
    input  wire [1:0] i_event,
    input  wire [1:0] i_clear,
    input  wire [1:0] i_enable,
    // Status and interrupt
    output reg  [1:0] o_status,
    output reg        o_irq
);

    wire [1:0] status_next;

    assign status_next = (o_status & ~i_clear) | i_event;

    always @(posedge i_clk_sys or posedge i_rst) begin
        if (i_rst) begin
            o_status <= 2'h0;
            o_irq    <= 1'b0;
        end else begin
            o_status <= status_next;
            o_irq    <= |(status_next & i_enable);
        end
    end

endmodule // tcc_irq
`default_nettype wire

// ---- tb/tcc_top_asserts.sv ----
// Purpose: Port checks for the tone cadence control block
// Assumes: One clock, asynchronous active-high reset
// Notes:   Outputs are judged two cycles after a control write
`timescale 1ns/100ps
`default_nettype none
module tcc_top_asserts #(
    parameter [19:0] STEP_CYCLES = 20'h0_0004
) (
    // Clock and reset
    input wire logic        i_clk_sys,
    input wire logic        i_rst,
    // Register port
    input wire logic [7:0]  i_addr,
    input wire logic [15:0] i_wdata,
    input wire logic        i_wr,
    input wire logic        i_rd,
    input wire logic [15:0] o_rdata,
    // Outputs
    input wire logic        o_tone_a_on,
    input wire logic        o_tone_b_on,
    input wire logic        o_gp_output_one,
    input wire logic        o_irq
);
    default clocking cb @(posedge i_clk_sys); endclocking
    default disable iff (i_rst);
    sequence ctrl_wr_s;
        i_wr && i_addr == 8'hDE;
    endsequence
    // Mask write not undone by a second enable write next cycle
    sequence en_off_s;
        (i_wr && i_addr == 8'hF2 && i_wdata[1:0] == 2'b00)
            ##1 !(i_wr && i_addr == 8'hF2);
    endsequence
    rdata_idle_a: assert property (!i_rd |=> o_rdata == 16'h0000)
        else $error("read data not zero when idle");
    unmapped_read_a: assert property ((i_rd && i_addr == 8'h10) |=>
        o_rdata == 16'h0000) else $error("unmapped read not zero");
    steady_out_a: assert property ((ctrl_wr_s ##0 i_wdata[7:6] == 2'b00)
        |-> ##2 (o_tone_a_on == $past(i_wdata[0], 2)
        && o_tone_b_on == $past(i_wdata[1], 2)
        && o_gp_output_one != $past(i_wdata[5], 2)))
        else $error("steady outputs wrong");
    cad_start_a: assert property ((ctrl_wr_s ##0 i_wdata[7] && i_wdata[0])
        |-> ##2 o_tone_a_on) else $error("cadence did not start on");
    all_off_a: assert property ((ctrl_wr_s ##0 i_wdata[5] == 1'b0
        && i_wdata[1:0] == 2'b00) |-> ##2 (!o_tone_a_on && !o_tone_b_on
        && o_gp_output_one)) else $error("outputs on with no enables");
    irq_mask_a: assert property (en_off_s |-> ##2 !o_irq)
        else $error("interrupt high while masked");
    relay_break_a: assert property ((ctrl_wr_s ##0 i_wdata[7:5] == 3'b111)
        |-> ##2 !o_gp_output_one) else $error("relay not broken");
    reset_val_a: assert property (disable iff (1'b0) i_rst |=>
        (!o_tone_a_on && !o_tone_b_on && o_gp_output_one && !o_irq))
        else $error("outputs not at reset values");
endmodule // tcc_top_asserts
bind tcc_top tcc_top_asserts #(.STEP_CYCLES(STEP_CYCLES)) tcc_top_asserts_i (
    .i_clk_sys(i_clk_sys), .i_rst(i_rst), .i_addr(i_addr),
    .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata),
    .o_tone_a_on(o_tone_a_on), .o_tone_b_on(o_tone_b_on),
    .o_gp_output_one(o_gp_output_one), .o_irq(o_irq));
`default_nettype wire

// ---- tb/tcc_top_test.sv ----
// Purpose: Self-checking bench for the tone cadence control block
// Assumes: Step of 4 clocks, so one cadence unit is 4 cycles
// Notes:   Short steps keep the run brief; ratios stay as documented
`timescale 1ns/100ps
`default_nettype none
module tcc_top_test;
    logic        i_clk_sys = 1'b0;
    logic        i_rst = 1'b1;
    logic [7:0]  i_addr = 8'h00;
    logic [15:0] i_wdata = 16'h0000;
    logic        i_wr = 1'b0;
    logic        i_rd = 1'b0;
    wire  [15:0] o_rdata;
    wire         o_tone_a_on, o_tone_b_on, o_gp_output_one, o_irq;
    logic [15:0] exp_q[$];
    logic        rd_seen = 1'b0;
    int          num_errors = 0;
    int          n_compared = 0;
    int          n;
    always #2.5 i_clk_sys = ~i_clk_sys;
    tcc_top #(.STEP_CYCLES(20'h0_0004)) tcc_top_i (.i_clk_sys(i_clk_sys),
        .i_rst(i_rst), .i_addr(i_addr), .i_wdata(i_wdata), .i_wr(i_wr),
        .i_rd(i_rd), .o_rdata(o_rdata), .o_tone_a_on(o_tone_a_on),
        .o_tone_b_on(o_tone_b_on), .o_gp_output_one(o_gp_output_one),
        .o_irq(o_irq));
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        n_compared++;
        if (got !== exp) begin
            num_errors++;
            $display("unexpected at %0t: got %h exp %h", $time, got, exp);
        end
    endtask
    // Read data stand only in the cycle after the strobe
    always @(posedge i_clk_sys) rd_seen <= i_rd;
    always @(negedge i_clk_sys) if (rd_seen) chk(o_rdata, exp_q.pop_front());
    task automatic wr(input logic [7:0] a, input logic [15:0] d);
        @(posedge i_clk_sys);
        i_wr <= 1'b1;
        i_addr <= a;
        i_wdata <= d;
        @(posedge i_clk_sys);
        i_wr <= 1'b0;
    endtask
    task automatic rd(input logic [7:0] a, input logic [15:0] e);
        exp_q.push_back(e);
        @(posedge i_clk_sys);
        i_rd <= 1'b1;
        i_addr <= a;
        @(posedge i_clk_sys);
        i_rd <= 1'b0;
    endtask
    task automatic out(input logic a, input logic b, input logic g);
        chk({13'h0000, o_tone_a_on, o_tone_b_on, o_gp_output_one},
            {13'h0000, a, b, g});
    endtask
    task automatic settle;
        repeat (2) @(negedge i_clk_sys);
    endtask
    task automatic run(input logic lv, output int k);
        k = 0;
        while (o_tone_a_on === lv && k < 400) begin
            @(negedge i_clk_sys);
            k++;
        end
    endtask
    task automatic stop_test;
        $display("compared %0d mismatches %0d", n_compared, num_errors);
        if (num_errors == 0 && n_compared > 0) $display("ALL TESTS PASSED");
        else $display("TESTS FAILED");
        $finish;
    endtask
    initial begin
        repeat (6000) @(posedge i_clk_sys);
        num_errors++;
        stop_test;
    end
    initial begin
        n = $urandom(32'h762b);
        repeat (3) @(posedge i_clk_sys);
        i_rst <= 1'b0;
        rd(8'hDE, 16'h0000);
        rd(8'hE0, 16'h0190);
        rd(8'hE2, 16'h0320);
        rd(8'h10, 16'h0000);
        n = $urandom & 32'h7ff;
        wr(8'hE0, n[15:0]);
        rd(8'hE0, n[15:0]);
        $display("test registers done");
        wr(8'hDE, 16'h0023);
        settle;
        repeat (30) begin
            @(negedge i_clk_sys);
            out(1'b1, 1'b1, 1'b0);
        end
        wr(8'hDE, 16'h0002);
        settle;
        out(1'b0, 1'b1, 1'b1);
        $display("test steady done");
        wr(8'hE0, 16'h0002);
        wr(8'hE2, 16'h0003);
        wr(8'hF2, 16'h0001);
        wr(8'hDE, 16'h0081);
        settle;
        run(1'b1, n);
        chk(n[15:0], 16'h0008);
        run(1'b0, n);
        chk(n[15:0], 16'h000C);
        run(1'b1, n);
        chk(n[15:0], 16'h0008);
        rd(8'hDE, 16'h0080);
        chk({15'h0000, o_irq}, 16'h0001);
        rd(8'hF0, 16'h0001);
        wr(8'hF2, 16'h0000);
        settle;
        // The enable passes two flops before it reaches the pin
        @(negedge i_clk_sys);
        chk({15'h0000, o_irq}, 16'h0000);
        $display("test continuous done");
        wr(8'hE2, 16'h0000);
        wr(8'hDE, 16'h0081);
        settle;
        repeat (30) begin
            @(negedge i_clk_sys);
            out(1'b1, 1'b0, 1'b1);
        end
        wr(8'hE2, 16'h0003);
        wr(8'hDE, 16'h0080);
        wr(8'hF1, 16'h0003);
        repeat (10) @(negedge i_clk_sys);
        rd(8'hF0, 16'h0001);
        out(1'b0, 1'b0, 1'b1);
        $display("test timer done");
        wr(8'hF1, 16'h0003);
        wr(8'hF2, 16'h0001);
        wr(8'hDE, 16'h00E1);
        settle;
        out(1'b1, 1'b0, 1'b0);
        run(1'b1, n);
        chk(n[15:0], 16'h0008);
        chk({15'h0000, o_irq}, 16'h0001);
        repeat (40) @(negedge i_clk_sys);
        out(1'b0, 1'b0, 1'b1);
        rd(8'hF0, 16'h0003);
        $display("test one_shot done");
        stop_test;
    end
endmodule // tcc_top_test
`default_nettype wire
